// file: occ_pkg.sv
package occ_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] OCC_CTRL_OFS   = 4'h0;
  localparam logic [3:0] OCC_PRIM_OFS   = 4'h4;
  localparam logic [3:0] OCC_SEC_OFS    = 4'h8;
  localparam logic [3:0] OCC_STAT_OFS   = 4'hc;

  // control register field positions
  localparam int OCC_ON_BIT   = 15;
  localparam int OCC_STOP_IN_IDLE_BIT = 13;
  localparam int OCC_WIDE_BIT = 5;
  localparam int OCC_FLT_BIT  = 4;
  localparam int OCC_TSEL_BIT = 3;
  localparam int OCC_MODE_LSB = 0;

  // status register field positions
  localparam int OCC_EVT_BIT  = 0;

  // values after reset
  localparam logic [31:0] OCC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OCC_CMP_RST  = 32'h0000_0000;

  // first channel governed by the second fault input
  localparam int OCC_FAULT_B_FIRST = 5;

  typedef enum logic [2:0] {
    OCC_M_OFF    = 3'b000,
    OCC_M_SET    = 3'b001,
    OCC_M_CLR    = 3'b010,
    OCC_M_TOGGLE = 3'b011,
    OCC_M_SINGLE = 3'b100,
    OCC_M_CONT   = 3'b101,
    OCC_M_PWM    = 3'b110,
    OCC_M_PWMF   = 3'b111
  } occ_mode_t;

endpackage : occ_pkg

// file: occ_match.sv
`timescale 1ns/100ps
module occ_match
  import occ_pkg::*;
(
  // operands
  input  wire logic [31:0] value,
  input  wire logic [31:0] count,
  input  wire logic        wide,
  // result
  output logic             equal
);

  // narrow mode ignores the upper halves entirely
  assign equal = wide ? (value == count) : (value[15:0] == count[15:0]);

endmodule : occ_match

// file: occ_top.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module occ_top
  import occ_pkg::*;
#(
  parameter int CHANNEL_INDEX = 1
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // time bases and device state
  input  wire logic [31:0] second_timer_count,
  input  wire logic [31:0] third_timer_count,
  input  wire logic        second_timer_rollover,
  input  wire logic        third_timer_rollover,
  input  wire logic        idle_mode,
  // fault pins, active low
  input  wire logic        fault_input_a_n,
  input  wire logic        fault_input_b_n,
  // channel outputs
  output logic             compare_output_pin,
  output logic             compare_event_flag
);
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];
  // fault pins come from outside, two stages before use
  logic [1:0] flta_sync_r;
  logic [1:0] fltb_sync_r;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flta_sync_r <= 2'b11;
      fltb_sync_r <= 2'b11;
    end
    else
    begin
      flta_sync_r <= {flta_sync_r[0], fault_input_a_n};
      fltb_sync_r <= {fltb_sync_r[0], fault_input_b_n};
    end
  end
  logic fault_s;
  assign fault_s = (CHANNEL_INDEX >= OCC_FAULT_B_FIRST) ? ~fltb_sync_r[1] : ~flta_sync_r[1];
  // register state
  logic        on_r, on_nxt;
  logic        stop_in_idle_r, stop_in_idle_nxt;
  logic        wide_r, wide_nxt;
  logic        tsel_r, tsel_nxt;
  occ_mode_t   mode_r, mode_nxt;
  logic [31:0] prim_r, prim_nxt;
  logic [31:0] sec_r, sec_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wait_r, wait_nxt;
  // channel state
  logic        pin_r, pin_nxt;
  logic        evt_r, evt_nxt;
  logic        flt_r, flt_nxt;
  logic        started_r, started_nxt;
  logic        done_r, done_nxt;
  occ_mode_t   mode_prev_r;
  logic [31:0] duty_r, duty_nxt;
  logic        p_eq_prev_r, s_eq_prev_r, d_eq_prev_r;
  logic        wr_ok, evt_clr;
  logic [31:0] be_mask, ctrl_rd;
  logic [31:0] cnt_sel;
  logic        roll_sel, run, steady;
  logic        p_eq, s_eq, d_eq, pm, sm, dm;
  // the transfer completes at the edge where waitrequest is seen low
  assign wr_ok = write & ~wait_r;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  always_comb
  begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[OCC_ON_BIT] = on_r;
    ctrl_rd[OCC_STOP_IN_IDLE_BIT] = stop_in_idle_r;
    ctrl_rd[OCC_WIDE_BIT] = wide_r;
    ctrl_rd[OCC_FLT_BIT] = flt_r & (mode_r == OCC_M_PWMF);
    ctrl_rd[OCC_TSEL_BIT] = tsel_r;
    ctrl_rd[OCC_MODE_LSB +: 3] = mode_r;
  end
  always_comb
  begin
    on_nxt = on_r;
    stop_in_idle_nxt = stop_in_idle_r;
    wide_nxt = wide_r;
    tsel_nxt = tsel_r;
    mode_nxt = mode_r;
    prim_nxt = prim_r;
    sec_nxt = sec_r;
    evt_clr = 1'b0;
    // one wait cycle per request, then a single ready cycle
    wait_nxt = ~((read | write) & wait_r);
    rdata_nxt = rdata_r;
    if (wr_ok)
    begin
      unique case (address)
        OCC_CTRL_OFS:
        begin
          // fault status is read-only, unimplemented bits are dropped
          if (byteenable[1])
          begin
            on_nxt = writedata[OCC_ON_BIT];
            stop_in_idle_nxt = writedata[OCC_STOP_IN_IDLE_BIT];
          end
          if (byteenable[0])
          begin
            wide_nxt = writedata[OCC_WIDE_BIT];
            tsel_nxt = writedata[OCC_TSEL_BIT];
            mode_nxt = occ_mode_t'(writedata[OCC_MODE_LSB +: 3]);
          end
        end
        OCC_PRIM_OFS: prim_nxt = (prim_r & ~be_mask) | (writedata & be_mask);
        OCC_SEC_OFS:  sec_nxt = (sec_r & ~be_mask) | (writedata & be_mask);
        OCC_STAT_OFS: evt_clr = byteenable[0] & writedata[OCC_EVT_BIT];
        default: ;
      endcase
    end
    if ((read | write) & wait_r)
    begin
      unique case (address)
        OCC_CTRL_OFS: rdata_nxt = ctrl_rd;
        OCC_PRIM_OFS: rdata_nxt = prim_r;
        OCC_SEC_OFS:  rdata_nxt = sec_r;
        OCC_STAT_OFS: rdata_nxt = {31'h0000_0000, evt_r};
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_r <= OCC_CTRL_RST[OCC_ON_BIT];
      stop_in_idle_r <= OCC_CTRL_RST[OCC_STOP_IN_IDLE_BIT];
      wide_r <= OCC_CTRL_RST[OCC_WIDE_BIT];
      tsel_r <= OCC_CTRL_RST[OCC_TSEL_BIT];
      mode_r <= OCC_M_OFF;
      prim_r <= OCC_CMP_RST;
      sec_r <= OCC_CMP_RST;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
    end
    else
    begin
      on_r <= on_nxt;
      stop_in_idle_r <= stop_in_idle_nxt;
      wide_r <= wide_nxt;
      tsel_r <= tsel_nxt;
      mode_r <= mode_nxt;
      prim_r <= prim_nxt;
      sec_r <= sec_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
    end
  end
  assign cnt_sel = tsel_r ? third_timer_count : second_timer_count;
  assign roll_sel = tsel_r ? third_timer_rollover : second_timer_rollover;
  occ_match u_prim (.value(prim_r), .count(cnt_sel), .wide(wide_r), .equal(p_eq));
  occ_match u_sec  (.value(sec_r), .count(cnt_sel), .wide(wide_r), .equal(s_eq));
  occ_match u_duty (.value(duty_r), .count(cnt_sel), .wide(wide_r), .equal(d_eq));
  // a match counts once, on the cycle equality is first seen
  assign pm = p_eq & ~p_eq_prev_r;
  assign sm = s_eq & ~s_eq_prev_r;
  assign dm = d_eq & ~d_eq_prev_r;
  assign run = on_r & ~(stop_in_idle_r & idle_mode);
  assign steady = run & started_r & (mode_r == mode_prev_r);
  always_comb
  begin
    pin_nxt = pin_r;
    started_nxt = started_r;
    done_nxt = done_r;
    duty_nxt = duty_r;
    flt_nxt = flt_r;
    evt_nxt = evt_r & ~evt_clr;
    if (!on_r || mode_r == OCC_M_OFF)
    begin
      // comparator idles but registers keep their contents
      pin_nxt = 1'b0;
      started_nxt = 1'b0;
      done_nxt = 1'b0;
    end
    else if (run)
    begin
      if (!started_r || mode_r != mode_prev_r)
      begin
        started_nxt = 1'b1;
        done_nxt = 1'b0;
        pin_nxt = (mode_r == OCC_M_CLR);
        duty_nxt = sec_r;
      end
      else
      begin
        unique case (mode_r)
          OCC_M_SET:    if (pm) pin_nxt = 1'b1;
          OCC_M_CLR:    if (pm) pin_nxt = 1'b0;
          OCC_M_TOGGLE: if (pm) pin_nxt = ~pin_r;
          OCC_M_SINGLE:
          begin
            if (pm && !done_r) pin_nxt = 1'b1;
            if (sm && pin_r)
            begin
              pin_nxt = 1'b0;
              done_nxt = 1'b1;
            end
          end
          OCC_M_CONT:
          begin
            if (pm) pin_nxt = 1'b1;
            if (sm) pin_nxt = 1'b0;
          end
          default:
          begin
            // pwm: duty reloads only at a period edge or at channel start, so a write cannot glitch the pulse
            if (roll_sel)
            begin
              pin_nxt = 1'b1;
              duty_nxt = sec_r;
            end
            else if (dm)
              pin_nxt = 1'b0;
          end
        endcase
        if (mode_r == OCC_M_PWMF)
        begin
          // cleared by hardware once the fault is gone at a period edge
          if (flt_r && !fault_s && roll_sel)
            flt_nxt = 1'b0;
          if (fault_s)
            flt_nxt = 1'b1;
          if (fault_s || flt_r)
            pin_nxt = 1'b0;
        end
        if ((pm || sm) && mode_r < OCC_M_PWM)
          evt_nxt = 1'b1;
        if ((dm || roll_sel) && mode_r >= OCC_M_PWM)
          evt_nxt = 1'b1;
        if (mode_r == OCC_M_PWMF && fault_s && !flt_r)
          evt_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_r <= 1'b0;
      started_r <= 1'b0;
      done_r <= 1'b0;
      duty_r <= OCC_CMP_RST;
      flt_r <= 1'b0;
      evt_r <= 1'b0;
      mode_prev_r <= OCC_M_OFF;
      p_eq_prev_r <= 1'b0;
      s_eq_prev_r <= 1'b0;
      d_eq_prev_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      started_r <= started_nxt;
      done_r <= done_nxt;
      duty_r <= duty_nxt;
      flt_r <= flt_nxt;
      evt_r <= evt_nxt;
      mode_prev_r <= mode_r;
      p_eq_prev_r <= p_eq;
      s_eq_prev_r <= s_eq;
      d_eq_prev_r <= d_eq;
    end
  end
  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign compare_output_pin = pin_r;
  assign compare_event_flag = evt_r;
  a_disable_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !on_r |=> !pin_r) else $error("pin not low while disabled");
  a_idle_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    on_r && stop_in_idle_r && idle_mode && mode_r != OCC_M_OFF |=> $stable(pin_r)) else $error("pin moved in idle halt");
  a_fault_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read && wait_r && address == OCC_CTRL_OFS && mode_r != OCC_M_PWMF) |=> !readdata[OCC_FLT_BIT])
    else $error("fault status visible outside fault mode");
  a_unimpl_bits_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read && wait_r && address == OCC_CTRL_OFS) |=> (readdata[31:16] == 16'h0000 && readdata[14] == 1'b0
    && readdata[12:6] == 7'h00)) else $error("unimplemented control bits not zero");
  a_fault_sets_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_PWMF && fault_s |=> flt_r ##0 !pin_r) else $error("fault not latched");
  a_fault_holds_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_PWMF && flt_r |=> !pin_r) else $error("output not shut down on fault");
  a_toggle_on_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_TOGGLE && pm |=> pin_r != $past(pin_r)) else $error("pin did not toggle");
  a_set_on_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_SET && pm |=> pin_r) else $error("pin not set on match");
  a_clear_on_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_CLR && pm |=> !pin_r) else $error("pin not cleared on match");
  a_pwm_period_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && mode_r == OCC_M_PWM && roll_sel |=> pin_r && duty_r == $past(sec_r)) else $error("pwm period start wrong");
  a_event_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    steady && pm && mode_r < OCC_M_PWM |=> evt_r ##1 (evt_r || $past(evt_clr)))
    else $error("event flag not raised and held");
endmodule : occ_top

// file: occ_timer_model.sv
`timescale 1ns/100ps
module occ_timer_model
  import occ_pkg::*;
#(
  parameter int PERIOD = 40
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // fault requests from the bench
  input  wire logic        fault_a,
  input  wire logic        fault_b,
  // time bases
  output logic [31:0]      second_timer_count,
  output logic [31:0]      third_timer_count,
  output logic             second_timer_rollover,
  output logic             third_timer_rollover,
  // fault pins, active low
  output logic             fault_input_a_n,
  output logic             fault_input_b_n
);
  logic [31:0] cnt_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= '0;
    else
      cnt_r <= (cnt_r == 32'(PERIOD - 1)) ? '0 : cnt_r + 32'h1;
  end

  assign second_timer_count    = cnt_r;
  // same phase but bit 16 set, so with the bench's compare values only a 16-bit compare can hit it
  assign third_timer_count     = 32'h0001_0000 | cnt_r;
  assign second_timer_rollover = (cnt_r == 32'(PERIOD - 1));
  assign third_timer_rollover  = second_timer_rollover;
  assign fault_input_a_n       = ~fault_a;
  assign fault_input_b_n       = ~fault_b;
endmodule : occ_timer_model

// file: tb_output_compare_control.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_output_compare_control
  import occ_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0]  flt;
    logic        idl;
    logic [3:0]  exp;
  } occ_row_t;

  logic        sys_clk = 1'b0;
  logic        reset_n, read, write, idle_mode, fault_a, fault_b;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, c2, c3;
  logic        waitrequest, r2, r3, fa_n, fb_n, compare_output_pin, compare_event_flag;
  int          num_errors = 0;
  int          checks_done = 0;
  int          smp [4] = '{5, 15, 25, 15};
  // pin seen at counts 5, 15, 25 and 15 of the next period; x is not checked
  occ_row_t    rows [14] = '{
    '{32'h0000_8001, 2'b00, 1'b0, 4'b0111},
    '{32'h0000_8002, 2'b00, 1'b0, 4'b1000},
    '{32'h0000_8003, 2'b00, 1'b0, 4'b0110},
    '{32'h0000_8004, 2'b00, 1'b0, 4'b0100},
    '{32'h0000_8005, 2'b00, 1'b0, 4'b0101},
    '{32'h0000_8006, 2'b01, 1'b0, 4'b1101},
    '{32'h0000_8007, 2'b10, 1'b0, 4'b1101},
    '{32'h0000_8000, 2'b00, 1'b0, 4'b0000},
    '{32'h0000_0001, 2'b00, 1'b0, 4'b0000},
    '{32'h0000_a001, 2'b00, 1'b1, 4'b0000},
    '{32'h0000_8001, 2'b00, 1'b1, 4'b0111},
    '{32'h0000_8009, 2'b00, 1'b0, 4'b0111},
    '{32'h0000_8029, 2'b00, 1'b0, 4'b0000},
    '{32'h0000_8021, 2'b00, 1'b0, 4'b0111}};

  always #5 sys_clk = ~sys_clk;

  occ_timer_model PARTNER (.sys_clk(sys_clk), .reset_n(reset_n), .fault_a(fault_a), .fault_b(fault_b),
    .second_timer_count(c2), .third_timer_count(c3), .second_timer_rollover(r2),
    .third_timer_rollover(r3), .fault_input_a_n(fa_n), .fault_input_b_n(fb_n));

  occ_top #(.CHANNEL_INDEX(1)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .second_timer_count(c2), .third_timer_count(c3),
    .second_timer_rollover(r2), .third_timer_rollover(r3), .idle_mode(idle_mode),
    .fault_input_a_n(fa_n), .fault_input_b_n(fb_n), .compare_output_pin(compare_output_pin),
    .compare_event_flag(compare_event_flag));

  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // the release edge is followed by an idle edge, so no access lands right after a disable
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= d;
    // only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask : rd_chk

  task automatic wait_cnt(input logic [31:0] v);
    do
    begin
      @(posedge sys_clk);
    end while (c2 !== v);
  endtask : wait_cnt

  initial
  begin
    reset_n = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0; writedata = 32'h0;
    byteenable = 4'hf; fault_a = 1'b0; fault_b = 1'b0; idle_mode = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("pin", 1'b0, compare_output_pin)
    rd_chk("ctrl", OCC_CTRL_OFS, OCC_CTRL_RST);
    wr(OCC_CTRL_OFS, 32'hffff_ffff);
    rd_chk("ctrl", OCC_CTRL_OFS, 32'h0000_a02f);
    wr(OCC_CTRL_OFS, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    wr(OCC_PRIM_OFS, 32'h0000_000a);
    wr(OCC_SEC_OFS, 32'h0000_0014);
    rd_chk("prim", OCC_PRIM_OFS, 32'h0000_000a);
    foreach (rows[i])
    begin
      wait_cnt(30);
      fault_a   <= rows[i].flt[0];
      fault_b   <= rows[i].flt[1];
      idle_mode <= rows[i].idl;
      wr(OCC_CTRL_OFS, rows[i].ctrl);
      for (int k = 0; k < 4; k++)
      begin
        wait_cnt(smp[k]);
        if (rows[i].exp[3-k] !== 1'bx) `CHK("pin", rows[i].exp[3-k], compare_output_pin)
      end
      wr(OCC_CTRL_OFS, 32'h0);
      fault_a   <= 1'b0;
      fault_b   <= 1'b0;
      idle_mode <= 1'b0;
    end
    `CHK("flag", 1'b1, compare_event_flag)
    rd_chk("status", OCC_STAT_OFS, 32'h1);
    wr(OCC_STAT_OFS, 32'h1);
    rd_chk("status", OCC_STAT_OFS, 32'h0);
    wait_cnt(30);
    wr(OCC_CTRL_OFS, 32'h0000_8007);
    wait_cnt(5);
    `CHK("pin", 1'b1, compare_output_pin)
    fault_a <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("pin", 1'b0, compare_output_pin)
    `CHK("flag", 1'b1, compare_event_flag)
    rd_chk("ctrl", OCC_CTRL_OFS, 32'h0000_8017);
    wr(OCC_CTRL_OFS, 32'h0000_8007);
    rd_chk("ctrl", OCC_CTRL_OFS, 32'h0000_8017);
    wr(OCC_CTRL_OFS, 32'h0000_8006);
    rd_chk("ctrl", OCC_CTRL_OFS, 32'h0000_8006);
    fault_a <= 1'b0;
    wr(OCC_CTRL_OFS, 32'h0000_8007);
    wait_cnt(5);
    wait_cnt(5);
    rd_chk("ctrl", OCC_CTRL_OFS, 32'h0000_8007);
    // reset in mid-run, while the flag is set and the channel is running
    reset_n <= 1'b0;
    @(posedge sys_clk);
    `CHK("waitrequest", 1'b1, waitrequest)
    `CHK("pin", 1'b0, compare_output_pin)
    `CHK("flag", 1'b0, compare_event_flag)
    `CHK("readdata", 32'h0, readdata)
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk("ctrl", OCC_CTRL_OFS, OCC_CTRL_RST);
    give_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict;
  end
endmodule : tb_output_compare_control
